// *** common/emac_pkg.sv ***
package emac_pkg;
	// register byte offsets
	localparam logic [11:0] OFF_NET_CTRL = 12'h000;
	localparam logic [11:0] OFF_NET_CFG = 12'h004;
	localparam logic [11:0] OFF_NET_STATUS = 12'h008;
	localparam logic [11:0] OFF_TX_QUEUE_PTR = 12'h01c;
	localparam logic [11:0] OFF_INT_STATUS = 12'h024;
	localparam logic [11:0] OFF_INT_ENABLE = 12'h028;
	localparam logic [11:0] OFF_INT_DISABLE = 12'h02c;
	localparam logic [11:0] OFF_INT_MASK = 12'h030;
	localparam logic [11:0] OFF_PHY_MGMT = 12'h034;
	localparam logic [11:0] OFF_HASH_LOW = 12'h080;
	localparam logic [11:0] OFF_HASH_HIGH = 12'h084;
	localparam logic [11:0] OFF_SPEC_ADDR1_LOW = 12'h098;
	localparam logic [11:0] OFF_SPEC_ADDR1_HIGH = 12'h09c;
	localparam logic [11:0] OFF_TS_NS_COMPARE = 12'h0dc;
	localparam logic [11:0] OFF_RX_LARGE_FRAME_COUNT = 12'h17c;
	// field positions
	localparam int CFG_MDC_DIV_LSB = 16;
	localparam int CFG_INT_W1C_BIT = 24;
	localparam int CTRL_TX_ENABLE_BIT = 3;
	localparam int CTRL_RX_ENABLE_BIT = 2;
	localparam int STATUS_MGMT_IDLE_BIT = 2;
	localparam int INT_MGMT_DONE_BIT = 0;
	localparam int INT_TS_CMP_BIT = 17;
	localparam int INT_COUNT = 18;
	localparam int NS_CMP_WIDTH = 22;
	localparam int ADDR_PAIRS = 5;
	// reset values
	localparam logic [31:0] NET_CFG_RESET = 32'h0008_0000;
	localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
	localparam logic [17:0] INT_MASK_RESET = 18'h3ffff;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int MDC_MIN_PERIOD_NS = 400;
	localparam int MDC_MIN_PERIOD_CYCLES = (MDC_MIN_PERIOD_NS * CLK_MHZ + 999) / 1000;
	localparam int MGMT_FRAME_BITS = 32;
	localparam int FRAME_MIN_BYTES = 1024;
	localparam int FRAME_MAX_BYTES = 1518;
	// half-period in clocks for each divider code
	// code 010 is divide by 64: 32 bits take 2048 clocks, near the 2000 expected
	function automatic logic [7:0] mdc_half_period(input logic [2:0] code);
		unique case (code)
			3'h0: mdc_half_period = 8'h08;
			3'h1: mdc_half_period = 8'h10;
			3'h2: mdc_half_period = 8'h20;
			3'h3: mdc_half_period = 8'h30;
			3'h4: mdc_half_period = 8'h40;
			3'h5: mdc_half_period = 8'h60;
			3'h6: mdc_half_period = 8'h80;
			3'h7: mdc_half_period = 8'hc0;
		endcase
	endfunction : mdc_half_period
endpackage : emac_pkg

// *** common/mgmt_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface mgmt_if;
	logic start;
	logic [31:0] load_word;
	logic [2:0] div_code;
	logic busy;
	logic done;
	logic [31:0] shift_word;
	modport ctrl (output start, output load_word, output div_code,
		input busy, input done, input shift_word);
	modport shifter (input start, input load_word, input div_code,
		output busy, output done, output shift_word);
endinterface : mgmt_if
`default_nettype wire

// *** logic/mdio_shifter.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdio_shifter (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	mgmt_if.shifter mg,
	input wire logic mdio_sync_in,
	output logic mdc_out,
	output logic mdio_o_out,
	output logic mdio_oe_out
);
	import emac_pkg::*;
	logic [7:0] div_cnt;
	logic [5:0] bit_cnt;
	logic [31:0] sreg;
	logic busy;
	logic done;
	wire [7:0] half = mdc_half_period(mg.div_code);
	wire half_tick = busy && (div_cnt == half - 8'h01);
	// rising edge samples and shifts out, falling edge counts bits
	wire rise_tick = half_tick && !mdc_out;
	wire fall_tick = half_tick && mdc_out;
	wire last_bit = fall_tick && (bit_cnt == 6'(MGMT_FRAME_BITS - 1));
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || !busy || half_tick) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			mdc_out <= 1'b0;
		end else if (half_tick) begin
			mdc_out <= !mdc_out;
		end
	end
	// msb out, lsb in per mdc
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			sreg <= ZERO_RESET;
		end else if (mg.start) begin
			sreg <= mg.load_word;
		end else if (rise_tick) begin
			sreg <= {sreg[30:0], mdio_sync_in};
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			busy <= 1'b0;
			bit_cnt <= 6'h00;
		end else if (mg.start) begin
			busy <= 1'b1;
			bit_cnt <= 6'h00;
		end else if (last_bit) begin
			busy <= 1'b0;
		end else if (fall_tick) begin
			bit_cnt <= bit_cnt + 6'h01;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			mdio_o_out <= 1'b0;
			mdio_oe_out <= 1'b0;
			done <= 1'b0;
		end else begin
			mdio_o_out <= sreg[31];
			mdio_oe_out <= busy;
			done <= last_bit;
		end
	end
	assign mg.busy = busy;
	assign mg.done = done;
	assign mg.shift_word = sreg;
endmodule : mdio_shifter
`default_nettype wire

// *** logic/ethernet_mac_mgmt_filter_irq.sv ***
// What this block does
// - lower write suspends match, upper resumes
// - filter writes accepted regardless of receive
// - address octets stored low byte first
// - management write starts shift, status reports
// - divider 010 gives about 2000 cycles
// - management done raises interrupt condition
// - msb drives mdio, lsb samples
// - reads show live shift contents
// - read frame returns phy data
// - mdc divided from bus clock
// - eighteen conditions ORed to one output
// - status clear-on-read or write-one-clear
// - reset disables all, enable/disable writes
// - mask reads one for disabled sources
// - compare value against counter bits 45:24
// - 32-bit read-only large frame counter
// - count only error-free frames
`timescale 1ns/1ps
`default_nettype none
module ethernet_mac_mgmt_filter_irq (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [11:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic mdio_i_in,
	output logic mdc_out,
	output logic mdio_o_out,
	output logic mdio_oe_out,
	input wire logic [47:0] timestamp_unit_count_in,
	input wire logic rx_frame_done_in,
	input wire logic [10:0] rx_frame_len_in,
	input wire logic rx_frame_ok_in,
	input wire logic [15:0] int_event_in,
	output logic [47:0] match_addr_out [emac_pkg::ADDR_PAIRS],
	output logic [emac_pkg::ADDR_PAIRS-1:0] match_enable_out,
	output logic tx_enable_out,
	output logic rx_enable_out,
	output logic [31:0] tx_queue_ptr_out,
	output logic irq_out
);
	import emac_pkg::*;

	// ==========================================
	// bus slave
	logic ack;
	logic [31:0] net_ctrl;
	logic [31:0] net_cfg;
	logic [31:0] phy_mgmt;
	logic [31:0] addr_low [ADDR_PAIRS];
	logic [15:0] addr_high [ADDR_PAIRS];
	logic [ADDR_PAIRS-1:0] pair_live;
	logic [NS_CMP_WIDTH-1:0] ns_compare;
	logic [31:0] large_frame_tally;
	logic [INT_COUNT-1:0] int_status;
	logic [INT_COUNT-1:0] int_mask;
	logic [31:0] rd_data;
	logic mdio_meta;
	logic mdio_sync;
	logic ts_match_q;
	logic [31:0] wmask;
	mgmt_if mg ();

	// one wait cycle per access: request taken on ack edge
	wire req = (avs_read_in || avs_write_in) && !ack;
	wire wr = avs_write_in && req;
	wire rd = avs_read_in && req;
	assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
		{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// pair index: 0 is hash, 1..4 specific address 1..4
	function automatic logic [3:0] pair_of(input logic [11:0] a);
		if (a == OFF_HASH_LOW || a == OFF_HASH_HIGH) begin
			pair_of = 4'h0;
		end else if (a >= OFF_SPEC_ADDR1_LOW && a <= OFF_SPEC_ADDR1_LOW + 12'h01f) begin
			pair_of = 4'(((a - OFF_SPEC_ADDR1_LOW) >> 3) + 12'h001);
		end else begin
			pair_of = 4'hf;
		end
	endfunction : pair_of

	wire [3:0] pair_idx = pair_of(avs_address_in);
	wire pair_hit = pair_idx != 4'hf;
	wire pair_upper = avs_address_in[2];
	wire [2:0] pidx = pair_idx[2:0];
	wire w1c_mode = net_cfg[CFG_INT_W1C_BIT];
	wire mgmt_write = wr && avs_address_in == OFF_PHY_MGMT && !mg.busy;
	wire int_rd = rd && avs_address_in == OFF_INT_STATUS;
	wire int_wr = wr && avs_address_in == OFF_INT_STATUS;
	// 22 bits 45:24 of nanosecond count
	wire ts_match = timestamp_unit_count_in[45:24] == ns_compare;
	// only good frames in window counted
	wire large_ok = rx_frame_done_in && rx_frame_ok_in &&
		rx_frame_len_in >= 11'(FRAME_MIN_BYTES) && rx_frame_len_in <= 11'(FRAME_MAX_BYTES);

	// ==========================================
	// management shifter
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			mdio_meta <= 1'b0;
			mdio_sync <= 1'b0;
		end else begin
			mdio_meta <= mdio_i_in;
			mdio_sync <= mdio_meta;
		end
	end
	assign mg.start = mgmt_write;
	assign mg.load_word = merge(phy_mgmt, avs_writedata_in, wmask);
	// code 010 gives 32-clock half period
	assign mg.div_code = net_cfg[CFG_MDC_DIV_LSB +: 3];

	mdio_shifter u_shifter (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.mg(mg),
		.mdio_sync_in(mdio_sync),
		.mdc_out(mdc_out),
		.mdio_o_out(mdio_o_out),
		.mdio_oe_out(mdio_oe_out)
	);

	// ==========================================
	// register writes
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			net_ctrl <= ZERO_RESET;
			net_cfg <= NET_CFG_RESET;
			tx_queue_ptr_out <= ZERO_RESET;
			ns_compare <= '0;
		end else if (wr) begin
			if (avs_address_in == OFF_NET_CTRL) begin
				net_ctrl <= merge(net_ctrl, avs_writedata_in, wmask);
			end
			if (avs_address_in == OFF_NET_CFG) begin
				net_cfg <= merge(net_cfg, avs_writedata_in, wmask);
			end
			// pointer accepted any time, software orders it
			if (avs_address_in == OFF_TX_QUEUE_PTR) begin
				tx_queue_ptr_out <= merge(tx_queue_ptr_out, avs_writedata_in, wmask);
			end
			if (avs_address_in == OFF_TS_NS_COMPARE) begin
				ns_compare <= NS_CMP_WIDTH'(merge({10'h000, ns_compare}, avs_writedata_in, wmask));
			end
		end
	end

	// finished word already holds phy read data
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			phy_mgmt <= ZERO_RESET;
		end else if (mg.done) begin
			phy_mgmt <= mg.shift_word;
		end else if (mgmt_write) begin
			phy_mgmt <= mg.load_word;
		end
	end

	// no receive-enable gate on filter writes
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < ADDR_PAIRS; i++) begin
				addr_low[i] <= ZERO_RESET;
				addr_high[i] <= 16'h0000;
			end
			pair_live <= '0;
		end else if (wr && pair_hit) begin
			if (pair_upper) begin
				addr_high[pidx] <= 16'(merge({16'h0000, addr_high[pidx]}, avs_writedata_in,
					wmask));
				pair_live[pidx] <= 1'b1;
			end else begin
				addr_low[pidx] <= merge(addr_low[pidx], avs_writedata_in, wmask);
				pair_live[pidx] <= 1'b0;
			end
		end
	end

	// first octet in low byte of lower word
	always_ff @(posedge sys_clk_in) begin
		for (int i = 0; i < ADDR_PAIRS; i++) begin
			match_addr_out[i] <= {addr_high[i], addr_low[i]};
		end
		match_enable_out <= pair_live;
		tx_enable_out <= net_ctrl[CTRL_TX_ENABLE_BIT];
		rx_enable_out <= net_ctrl[CTRL_RX_ENABLE_BIT];
	end

	// ==========================================
	// interrupts
	wire [INT_COUNT-1:0] int_events = {ts_match && !ts_match_q, int_event_in, mg.done};
	wire [INT_COUNT-1:0] int_clear = int_rd && !w1c_mode ? {INT_COUNT{1'b1}} :
		int_wr && w1c_mode ? avs_writedata_in[INT_COUNT-1:0] : '0;
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			int_status <= '0;
			ts_match_q <= 1'b0;
		end else begin
			// set wins over either clear style
			// timestamp equality edge sets bit 17
			int_status <= (int_status & ~int_clear) | int_events;
			ts_match_q <= ts_match;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			int_mask <= INT_MASK_RESET;
		end else if (wr && avs_address_in == OFF_INT_ENABLE) begin
			int_mask <= int_mask & ~avs_writedata_in[INT_COUNT-1:0];
		end else if (wr && avs_address_in == OFF_INT_DISABLE) begin
			int_mask <= int_mask | avs_writedata_in[INT_COUNT-1:0];
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(int_status & ~int_mask);
		end
	end

	// ==========================================
	// large frame counter
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			large_frame_tally <= ZERO_RESET;
		end else if (large_ok) begin
			large_frame_tally <= large_frame_tally + 32'h0000_0001;
		end
	end

	// ==========================================
	// read mux
	always_comb begin
		rd_data = ZERO_RESET;
		unique case (avs_address_in)
			OFF_NET_CTRL: rd_data = net_ctrl;
			OFF_NET_CFG: rd_data = net_cfg;
			// status idle bit low while busy
			OFF_NET_STATUS: rd_data[STATUS_MGMT_IDLE_BIT] = !mg.busy && !mg.done && !mgmt_write;
			OFF_TX_QUEUE_PTR: rd_data = tx_queue_ptr_out;
			OFF_INT_STATUS: rd_data[INT_COUNT-1:0] = int_status;
			OFF_INT_MASK: rd_data[INT_COUNT-1:0] = int_mask;
			OFF_PHY_MGMT: rd_data = (mg.busy || mg.done) ? mg.shift_word : phy_mgmt;
			OFF_TS_NS_COMPARE: rd_data[NS_CMP_WIDTH-1:0] = ns_compare;
			OFF_RX_LARGE_FRAME_COUNT: rd_data = large_frame_tally;
			default: begin
				if (pair_hit) begin
					rd_data = pair_upper ? {16'h0000, addr_high[pidx]} : addr_low[pidx];
				end
			end
		endcase
	end

	// waitrequest kept in its own flop so the pin leaves a register
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ack <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= ZERO_RESET;
		end else begin
			ack <= req;
			avs_waitrequest_out <= !req;
			if (rd) begin
				avs_readdata_out <= rd_data;
			end
		end
	end
endmodule : ethernet_mac_mgmt_filter_irq
`default_nettype wire

// *** verif/emac_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module emac_props import emac_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [11:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic avs_waitrequest_out,
	input wire logic mdc_out,
	input wire logic mdio_o_out,
	input wire logic mdio_oe_out,
	input wire logic [47:0] match_addr_out [ADDR_PAIRS],
	input wire logic [ADDR_PAIRS-1:0] match_enable_out,
	input wire logic irq_out
);
	default clocking dc @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	logic wr_ack;
	assign wr_ack = avs_write_in && !avs_waitrequest_out;
	// ==========
	// bus
	property p_answer;
		$rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out;
	endproperty
	a_answer: assert property (p_answer) else $error("late answer");
	property p_one;
		!avs_waitrequest_out |=> avs_waitrequest_out;
	endproperty
	a_one: assert property (p_one) else $error("answer held too long");
	// ==========
	// filter pair
	property p_lower;
		wr_ack && avs_address_in == OFF_SPEC_ADDR1_LOW |=> !match_enable_out[1];
	endproperty
	a_lower: assert property (p_lower) else $error("match not suspended");
	property p_upper;
		wr_ack && avs_address_in == OFF_SPEC_ADDR1_HIGH |=> match_enable_out[1];
	endproperty
	a_upper: assert property (p_upper) else $error("match not resumed");
	property p_order;
		wr_ack && avs_address_in == OFF_SPEC_ADDR1_HIGH
			|=> match_addr_out[1][47:32] == $past(avs_writedata_in[15:0]);
	endproperty
	a_order: assert property (p_order) else $error("upper octets misplaced");
	// ==========
	// management link
	property p_start;
		wr_ack && avs_address_in == OFF_PHY_MGMT && !mdio_oe_out |-> ##[1:4] mdio_oe_out;
	endproperty
	a_start: assert property (p_start) else $error("shift not started");
	// shortest half period of any code is eight clocks
	property p_mdc;
		$rose(mdc_out) |-> mdc_out [*8];
	endproperty
	a_mdc: assert property (p_mdc) else $error("mdc too fast");
	property p_mdio;
		mdio_oe_out && $rose(mdc_out) |-> $stable(mdio_o_out);
	endproperty
	a_mdio: assert property (p_mdio) else $error("data moved on mdc rise");
	property p_irq_rst;
		$past(sys_rst_in) |-> !irq_out;
	endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
endmodule : emac_props
bind ethernet_mac_mgmt_filter_irq emac_props i_props (.sys_clk_in, .sys_rst_in,
	.avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_waitrequest_out,
	.mdc_out, .mdio_o_out, .mdio_oe_out, .match_addr_out, .match_enable_out, .irq_out);
`default_nettype wire

// *** verif/mdio_phy_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdio_phy_model (
	input wire logic mdc_in,
	input wire logic mdio_in,
	input wire logic active_in,
	input wire logic [15:0] read_data_in,
	output logic mdio_out,
	output logic mdio_oe_out,
	output logic [31:0] seen_out
);
	int n;
	logic rd_op;
	initial begin
		n = 0;
		rd_op = 1'b0;
		mdio_out = 1'b1;
		mdio_oe_out = 1'b0;
		seen_out = '0;
	end
	always @(negedge active_in) n = 0;
	// capture before driving, so seen_out also records own read bits
	always @(posedge mdc_in) begin
		if (active_in) begin
			seen_out = {seen_out[30:0], mdio_in};
			if (n == 3) rd_op = (seen_out[1:0] == 2'b10);
			mdio_oe_out = rd_op && n >= 14 && n <= 30;
			if (n >= 15 && n <= 30) mdio_out = read_data_in[30-n];
			else mdio_out = 1'b0;
			n = n + 1;
		end
	end
endmodule : mdio_phy_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import emac_pkg::*;
	logic sys_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [11:0] adr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = '0;
	logic [47:0] ts = '1;
	logic fdone = 1'b0;
	logic [10:0] flen = '0;
	logic fok = 1'b0;
	logic [15:0] ev = '0;
	logic [31:0] rdat, txq, q, seen;
	logic wreq, mdio_i, mdc, mdio_o, mdio_oe, phy_o, phy_oe, irq, txe, rxe;
	logic [47:0] maddr [ADDR_PAIRS];
	logic [ADDR_PAIRS-1:0] men;
	logic [31:0] frm [2] = '{32'h5012_a5c3, 32'h6012_1234};
	logic [31:0] res [2] = '{32'h5012_a5c3, 32'h6012_beef};
	int fail_count = 0;
	int compares = 0;
	time t0;
	always #5 sys_clk_in = ~sys_clk_in;
	// pulled-up line; the phy wins during its turn
	assign mdio_i = phy_oe ? phy_o : (mdio_oe ? mdio_o : 1'b1);
	ethernet_mac_mgmt_filter_irq i_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.mdio_i_in(mdio_i), .mdc_out(mdc), .mdio_o_out(mdio_o), .mdio_oe_out(mdio_oe),
		.timestamp_unit_count_in(ts), .rx_frame_done_in(fdone), .rx_frame_len_in(flen),
		.rx_frame_ok_in(fok), .int_event_in(ev), .match_addr_out(maddr),
		.match_enable_out(men), .tx_enable_out(txe), .rx_enable_out(rxe),
		.tx_queue_ptr_out(txq), .irq_out(irq));
	mdio_phy_model i_phy (.mdc_in(mdc), .mdio_in(mdio_i), .active_in(mdio_oe),
		.read_data_in(16'hbeef), .mdio_out(phy_o), .mdio_oe_out(phy_oe), .seen_out(seen));
	// ==========
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// request stands until waitrequest is sampled low at a rising edge
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge sys_clk_in);
		end while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : acc
	// registered outputs need an edge or two after the access
	task automatic settle;
		repeat (2) @(posedge sys_clk_in);
	endtask : settle
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		acc(1'b0, a, '0);
		chk(q, e);
	endtask : rchk
	task automatic pulse(input logic [15:0] b);
		@(posedge sys_clk_in);
		ev <= b;
		@(posedge sys_clk_in);
		ev <= '0;
		repeat (3) @(posedge sys_clk_in);
	endtask : pulse
	task automatic frame(input logic [10:0] len, input logic ok);
		@(posedge sys_clk_in);
		flen <= len;
		fok <= ok;
		fdone <= 1'b1;
		@(posedge sys_clk_in);
		fdone <= 1'b0;
	endtask : frame
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		fail_count++;
		test_done();
	end
	// ==========
	// tests
	initial begin
		repeat (6) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		rchk(OFF_INT_MASK, 32'h0003_ffff);
		rchk(OFF_TS_NS_COMPARE, '0);
		rchk(OFF_RX_LARGE_FRAME_COUNT, '0);
		rchk(12'hffc, '0);
		$display("reset test done");
		// hash pair written while receive is off
		acc(1'b1, OFF_HASH_LOW, 32'h1122_3344);
		acc(1'b1, OFF_HASH_HIGH, 32'h0000_5566);
		acc(1'b1, OFF_NET_CTRL, 32'h0000_0004);
		acc(1'b1, OFF_SPEC_ADDR1_LOW, 32'h8765_4321);
		settle();
		chk(32'(men[1]), 32'h0);
		chk(32'(men[0]), 32'h1);
		chk(maddr[0][47:16], 32'h5566_1122);
		acc(1'b1, OFF_SPEC_ADDR1_HIGH, 32'h0000_cba9);
		settle();
		chk(32'(men[1]), 32'h1);
		chk(maddr[1][47:16], 32'hcba9_8765);
		chk({16'h0, maddr[1][15:0]}, 32'h0000_4321);
		acc(1'b1, OFF_SPEC_ADDR1_LOW, 32'h8765_4321);
		settle();
		chk(32'(men[1]), 32'h0);
		acc(1'b1, OFF_SPEC_ADDR1_HIGH, 32'hffff_cba9);
		settle();
		chk(32'(men[1]), 32'h1);
		rchk(OFF_SPEC_ADDR1_HIGH, 32'h0000_cba9);
		rchk(OFF_SPEC_ADDR1_LOW, 32'h8765_4321);
		$display("filter test done");
		acc(1'b1, OFF_INT_ENABLE, 32'h0000_0002);
		rchk(OFF_INT_MASK, 32'h0003_fffd);
		pulse(16'h0001);
		chk(32'(irq), 32'h1);
		rchk(OFF_INT_STATUS, 32'h0000_0002);
		rchk(OFF_INT_STATUS, '0);
		chk(32'(irq), 32'h0);
		acc(1'b1, OFF_INT_DISABLE, 32'h0000_0002);
		rchk(OFF_INT_MASK, 32'h0003_ffff);
		pulse(16'h0001);
		chk(32'(irq), 32'h0);
		acc(1'b0, OFF_INT_STATUS, '0);
		$display("interrupt test done");
		// divider 010 keeps mdc under 2.5 MHz
		acc(1'b1, OFF_NET_CFG, 32'h0002_0000);
		acc(1'b1, OFF_INT_ENABLE, 32'h0000_0001);
		for (int i = 0; i < 2; i++) begin
			acc(1'b1, OFF_PHY_MGMT, frm[i]);
			t0 = $time;
			rchk(OFF_NET_STATUS, '0);
			// refused while shifting, must not disturb the frame
			acc(1'b1, OFF_PHY_MGMT, 32'hffff_ffff);
			@(posedge mdc);
			rchk(OFF_PHY_MGMT, {frm[i][30:0], frm[i][31]});
			do begin
				acc(1'b0, OFF_NET_STATUS, '0);
			end while (q[2] !== 1'b1);
			chk(32'(($time - t0) / 10 > 1800 && ($time - t0) / 10 < 2300), 32'h1);
			settle();
			chk(32'(irq), 32'h1);
			rchk(OFF_INT_STATUS, 32'h0000_0001);
			chk(seen, res[i]);
			rchk(OFF_PHY_MGMT, res[i]);
		end
		$display("management test done");
		acc(1'b1, OFF_TS_NS_COMPARE, 32'h002a_bcde);
		rchk(OFF_TS_NS_COMPARE, 32'h002a_bcde);
		acc(1'b1, OFF_INT_ENABLE, 32'h0002_0000);
		ts <= {2'b11, 22'h2a_bcdf, 24'h00_0000};
		pulse('0);
		chk(32'(irq), 32'h0);
		ts <= {2'b11, 22'h2a_bcde, 24'h12_3456};
		pulse('0);
		chk(32'(irq), 32'h1);
		rchk(OFF_INT_STATUS, 32'h0002_0000);
		$display("timestamp test done");
		frame(11'd1024, 1'b1);
		frame(11'd1518, 1'b1);
		frame(11'd1023, 1'b1);
		frame(11'd1519, 1'b1);
		frame(11'd1200, 1'b0);
		rchk(OFF_RX_LARGE_FRAME_COUNT, 32'h0000_0002);
		acc(1'b1, OFF_RX_LARGE_FRAME_COUNT, 32'h0000_0055);
		rchk(OFF_RX_LARGE_FRAME_COUNT, 32'h0000_0002);
		$display("counter test done");
		acc(1'b1, OFF_TX_QUEUE_PTR, 32'h2000_0040);
		acc(1'b1, OFF_NET_CTRL, 32'h0000_000c);
		settle();
		chk(txq, 32'h2000_0040);
		chk(32'(txe), 32'h1);
		chk(32'(rxe), 32'h1);
		acc(1'b1, OFF_NET_CFG, 32'h0102_0000);
		acc(1'b1, OFF_INT_ENABLE, 32'h0000_0002);
		pulse(16'h0001);
		rchk(OFF_INT_STATUS, 32'h0000_0002);
		rchk(OFF_INT_STATUS, 32'h0000_0002);
		acc(1'b1, OFF_INT_STATUS, 32'h0000_0002);
		rchk(OFF_INT_STATUS, '0);
		$display("transmit and clear-mode test done");
		test_done();
	end
endmodule : testbench
`default_nettype wire
